// ===== design/fbp_defines.svh
// Constants for the flash bus-operation and sector-protect host controller.
// What this block does
// - Read data only while chip select and output gate both low.
// - Write cycle only with chip select and write strobe low, gate high.
// - Id read: id line at high voltage, bits one and six low; bit zero picks code.
// - Protect: id line and gate at high voltage, strobe low for 100 us.
// - Host skips an unprotect unless it has protected every sector since reset or the last unprotect.
// - Unprotect: id, gate, select high voltage; bits six, twelve, sector high; 10 ms.
// - Unprotect verify reads 00h per sector; the bench checks all 8 sectors.
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH
`define FBP_SECTORS         8
`define FBP_ADDR_W          19
`define FBP_BIT_ONE         1
`define FBP_BIT_SIX         6
`define FBP_BIT_TWELVE      12
`define FBP_SECT_LSB        16
`define FBP_PROT_YES        8'h01
`define FBP_PROT_NO         8'h00
`define FBP_CLK_NS          100
`define FBP_PROTECT_NS      100000
`define FBP_UNPROTECT_NS    10000000
`define FBP_PROTECT_CYC     ((`FBP_PROTECT_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS)
`define FBP_UNPROTECT_CYC   ((`FBP_UNPROTECT_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS)
`define FBP_SETUP_CYC       2
`define FBP_READ_CYC        2
`endif

// ===== design/fbp_pkg.sv
// Types shared by the flash bus-operation host controller.
`default_nettype none
package fbp_pkg;
    // Operations the user may request.
    typedef enum logic [2:0] {
        FBP_OP_READ,
        FBP_OP_WRITE,
        FBP_OP_ID_READ,
        FBP_OP_PROTECT,
        FBP_OP_PROT_CHECK,
        FBP_OP_UNPROTECT
    } fbp_op_t;

    // Pins toward the flash, with separate high-voltage qualifiers.
    typedef struct packed {
        logic        cs_n;
        logic        oe_n;
        logic        we_n;
        logic        cs_hv;
        logic        oe_hv;
        logic        id_hv;
        logic [18:0] addr;
        logic [7:0]  dq_o;
        logic        dq_oe;
    } fbp_pins_t;

    // One request from the user side.
    typedef struct packed {
        fbp_op_t     op;
        logic [18:0] addr;
        logic [7:0]  data;
    } fbp_req_t;
endpackage
`default_nettype wire

// ===== design/fbp_timer.sv
// Down counter that marks the end of a timed phase.
`default_nettype none
module fbp_timer #(
    parameter int W = 17
) (
    // Clock and reset.
    input  wire logic         ref_clk_in,
    input  wire logic         rstn_in,
    // Control.
    input  wire logic         load_in,
    input  wire logic [W-1:0] count_in,
    output logic              done_out
);
    logic [W-1:0] remain;

    // Loading restarts the count; done stays high once it reaches zero.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            remain <= '0;
        end else if (load_in) begin
            remain <= count_in;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done_out = (remain == '0) && !load_in;
endmodule
`default_nettype wire

// ===== design/fbp_host.sv
// Host controller that drives the flash pins for bus and protection operations.
`include "fbp_defines.svh"
`default_nettype none
module fbp_host #(
    parameter int PROTECT_CYC   = `FBP_PROTECT_CYC,
    parameter int UNPROTECT_CYC = `FBP_UNPROTECT_CYC
) (
    // Clock and reset.
    input  wire logic             ref_clk_in,
    input  wire logic             rstn_in,
    // User request and answer.
    input  wire logic             req_valid_in,
    input  wire fbp_pkg::fbp_req_t req_in,
    output logic                  req_ready_out,
    output logic                  rsp_valid_out,
    output logic [7:0]            rsp_data_out,
    // Flash pins.
    output var fbp_pkg::fbp_pins_t pins_out,
    input  wire logic [7:0]       dq_in
);
    localparam int TW = 17;

    typedef enum logic [2:0] {
        FBP_IDLE,
        FBP_SETUP,
        FBP_STROBE,
        FBP_SAMPLE,
        FBP_RELEASE
    } fbp_state_t;

    fbp_state_t        state;
    fbp_pkg::fbp_req_t cur;
    fbp_pkg::fbp_pins_t pins;
    logic [2:0]        cnt;
    logic              tmr_load;
    logic [TW-1:0]     tmr_count;
    logic              tmr_done;
    logic              is_read;
    logic [`FBP_SECTORS-1:0] prot_seen;
    logic [TW-1:0]     low_cnt;

    // Protect and unprotect pulses are long, so they share one counter.
    fbp_timer #(.W(TW)) u_timer (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .load_in    (tmr_load),
        .count_in   (tmr_count),
        .done_out   (tmr_done)
    );

    assign is_read = (cur.op == fbp_pkg::FBP_OP_READ) || (cur.op == fbp_pkg::FBP_OP_ID_READ)
                  || (cur.op == fbp_pkg::FBP_OP_PROT_CHECK);
    assign req_ready_out = (state == FBP_IDLE);
    assign pins_out = pins;
    assign tmr_load = (state == FBP_SETUP) && (cnt == 3'h0) && !is_read
                   && (cur.op != fbp_pkg::FBP_OP_WRITE);
    assign tmr_count = (cur.op == fbp_pkg::FBP_OP_UNPROTECT) ? TW'(UNPROTECT_CYC)
                                                             : TW'(PROTECT_CYC);

    // Sequencer: setup, strobe or read window, then release back to idle.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= FBP_IDLE;
            cnt   <= 3'h0;
            cur   <= '0;
        end else begin
            case (state)
                FBP_IDLE: begin
                    if (req_valid_in) begin
                        cur   <= req_in;
                        cnt   <= 3'(`FBP_SETUP_CYC);
                        state <= FBP_SETUP;
                    end
                end
                FBP_SETUP: begin
                    if (cnt != 3'h0) begin
                        cnt <= cnt - 3'h1;
                    end else if (is_read) begin
                        cnt   <= 3'(`FBP_READ_CYC);
                        state <= FBP_SAMPLE;
                    end else if ((cur.op == fbp_pkg::FBP_OP_UNPROTECT) && !(&prot_seen)) begin
                        state <= FBP_RELEASE;
                    end else begin
                        cnt   <= 3'(`FBP_SETUP_CYC);
                        state <= FBP_STROBE;
                    end
                end
                FBP_STROBE: begin
                    // Plain writes use a short pulse; protection waits for the timer.
                    if (cur.op == fbp_pkg::FBP_OP_WRITE) begin
                        if (cnt != 3'h0) cnt <= cnt - 3'h1;
                        else state <= FBP_RELEASE;
                    end else if (tmr_done) begin
                        state <= FBP_RELEASE;
                    end
                end
                FBP_SAMPLE: begin
                    if (cnt != 3'h0) cnt <= cnt - 3'h1;
                    else state <= FBP_RELEASE;
                end
                FBP_RELEASE: state <= FBP_IDLE;
                default: state <= FBP_IDLE;
            endcase
        end
    end

    // Pin levels per operation; the data bus is released before any read.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
            if (state == FBP_SETUP || state == FBP_STROBE || state == FBP_SAMPLE) begin
                pins.addr <= cur.addr;
                case (cur.op)
                    fbp_pkg::FBP_OP_READ: begin
                        pins.cs_n <= 1'b0;
                        pins.oe_n <= (state != FBP_SAMPLE) && !(state == FBP_SETUP);
                    end
                    fbp_pkg::FBP_OP_WRITE: begin
                        // Gate stays high and data drives before the strobe falls.
                        pins.cs_n  <= 1'b0;
                        pins.dq_o  <= cur.data;
                        pins.dq_oe <= 1'b1;
                        pins.we_n  <= (state != FBP_STROBE) || (cnt == 3'h0);
                    end
                    fbp_pkg::FBP_OP_ID_READ, fbp_pkg::FBP_OP_PROT_CHECK: begin
                        pins.cs_n  <= 1'b0;
                        pins.oe_n  <= 1'b0;
                        pins.id_hv <= 1'b1;
                        pins.addr[`FBP_BIT_SIX] <= 1'b0;
                        if (cur.op == fbp_pkg::FBP_OP_ID_READ) begin
                            pins.addr[`FBP_BIT_ONE] <= 1'b0;
                        end else begin
                            pins.addr[`FBP_BIT_ONE] <= 1'b1;
                        end
                    end
                    fbp_pkg::FBP_OP_PROTECT: begin
                        pins.cs_n  <= 1'b0;
                        pins.id_hv <= 1'b1;
                        pins.oe_hv <= 1'b1;
                        // The strobe rises a cycle before the high voltage drops, so the
                        // device still sees protect levels when the pulse ends.
                        pins.we_n  <= (state != FBP_STROBE) || tmr_done;
                    end
                    fbp_pkg::FBP_OP_UNPROTECT: begin
                        pins.cs_hv <= 1'b1;
                        pins.id_hv <= 1'b1;
                        pins.oe_hv <= 1'b1;
                        pins.addr[`FBP_BIT_SIX]    <= 1'b1;
                        pins.addr[`FBP_BIT_TWELVE] <= 1'b1;
                        pins.addr[`FBP_SECT_LSB]   <= 1'b1;
                        pins.we_n  <= (state != FBP_STROBE) || tmr_done;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Sectors protected since reset or the last unprotect; a part protected before reset is unknown here,
    // so it must be protected again before this block will unprotect it.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prot_seen <= '0;
        end else if (state == FBP_STROBE && tmr_done) begin
            if (cur.op == fbp_pkg::FBP_OP_PROTECT) begin
                prot_seen[cur.addr[`FBP_SECT_LSB +: 3]] <= 1'b1;
            end else if (cur.op == fbp_pkg::FBP_OP_UNPROTECT) begin
                prot_seen <= '0;
            end
        end
    end

    // Length of the current strobe pulse in cycles, held at its top value.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_cnt <= '0;
        end else if (pins.we_n) begin
            low_cnt <= '0;
        end else if (low_cnt != '1) begin
            low_cnt <= low_cnt + TW'(1);
        end
    end

    // Read data is sampled at the end of the window, while gate is low.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rsp_data_out  <= 8'h00;
            rsp_valid_out <= 1'b0;
        end else begin
            rsp_valid_out <= 1'b0;
            if (state == FBP_SAMPLE && cnt == 3'h0) begin
                rsp_data_out  <= dq_in;
                rsp_valid_out <= 1'b1;
            end
        end
    end

    // Bus contention guard: never drive data while the gate is low.
    property p_no_contention;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        pins.dq_oe |-> pins.oe_n && !pins.oe_hv;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("Data driven with gate low.");

    property p_write_levels;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !pins.we_n && !pins.oe_hv && !pins.cs_hv |-> !pins.cs_n && pins.oe_n;
    endproperty
    a_write_levels: assert property (p_write_levels)
        else $error("Bad write levels.");

    property p_read_levels;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        rsp_valid_out |-> $past(!pins.cs_n && !pins.oe_n);
    endproperty
    a_read_levels: assert property (p_read_levels)
        else $error("Read sampled off window.");

    property p_protect_hv;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !pins.we_n && pins.oe_hv |-> pins.id_hv;
    endproperty
    a_protect_hv: assert property (p_protect_hv)
        else $error("Protect without id voltage.");

    property p_unprotect_bits;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        pins.cs_hv |-> pins.addr[`FBP_BIT_SIX] && pins.addr[`FBP_BIT_TWELVE] && pins.oe_hv;
    endproperty
    a_unprotect_bits: assert property (p_unprotect_bits)
        else $error("Unprotect bits wrong.");

    property p_id_bits;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        pins.id_hv && !pins.oe_n |-> !pins.addr[`FBP_BIT_SIX] && pins.we_n;
    endproperty
    a_id_bits: assert property (p_id_bits)
        else $error("Id read bits wrong.");

    property p_pulse_len;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(pins.we_n) && pins.oe_hv |-> !pins.we_n [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("Protect pulse too short.");

    // The full pulse time is counted, since a repetition cannot reach it.
    property p_pulse_time;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(pins.we_n) && pins.oe_hv
            |-> low_cnt >= (pins.cs_hv ? TW'(UNPROTECT_CYC) : TW'(PROTECT_CYC));
    endproperty
    a_pulse_time: assert property (p_pulse_time)
        else $error("High voltage pulse ended early.");

    property p_unprotect_order;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(pins.we_n) && pins.cs_hv |-> &prot_seen;
    endproperty
    a_unprotect_order: assert property (p_unprotect_order)
        else $error("Unprotect before all sectors protected.");

    property p_hv_exclusive;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        pins.oe_hv |-> pins.oe_n;
    endproperty
    a_hv_exclusive: assert property (p_hv_exclusive)
        else $error("Gate low at high voltage.");

    c_read: cover property (@(posedge ref_clk_in) rsp_valid_out);
    c_protect: cover property (@(posedge ref_clk_in) $rose(pins.we_n) && pins.oe_hv && !pins.cs_hv);
    c_unprotect: cover property (@(posedge ref_clk_in) $rose(pins.we_n) && pins.cs_hv);
endmodule
`default_nettype wire

// ===== verif/fbp_flash_model.sv
// Behavioural model of the flash device as seen from the host pins.
`default_nettype none
module fbp_flash_model #(
    parameter time        PROT_NS   = 2000,
    parameter time        UNPROT_NS = 2000,
    parameter time        ERASE_NS  = 10000,
    parameter logic [7:0] MAKER     = 8'h5A, // Arbitrary value.
    parameter logic [7:0] PART      = 8'hC3  // Arbitrary value.
) (
    // Pins and shared data bus.
    input  wire fbp_pkg::fbp_pins_t pins_in,
    input  wire logic [7:0]         bus_in,
    // Device data output.
    output logic [7:0]              dq_out,
    output logic                    drive_out
);
    timeunit 1ns;
    timeprecision 1ns;
    fbp_pkg::fbp_pins_t p;
    logic [7:0]         mem [logic [18:0]];
    logic [7:0]         prot;
    logic [18:0]        wr_addr;
    logic               sig_mode;
    logic               wr_act;
    logic [7:0]         rd_val;
    time                t_fall;
    logic               busy;
    logic               susp;
    logic               tog;
    logic [2:0]         e_sect;
    time                e_left;
    time                t_go;

    assign p = pins_in;
    // Nothing is protected and the array is selected at power-up.
    initial begin
        prot = 8'h00;
        sig_mode = 1'b0;
        t_fall = 0;
        busy = 1'b0;
        susp = 1'b0;
        tog = 1'b0;
        e_sect = 3'h0;
        e_left = 0;
        t_go = 0;
    end
    // High voltage is its own qualifier, so no normal write fires under it.
    assign wr_act = !p.cs_n && !p.we_n && p.oe_n && !p.oe_hv && !p.cs_hv && !p.id_hv;
    // Address taken on the later falling edge of strobe or select.
    always @(posedge wr_act) wr_addr = p.addr;
    // Data taken on the earlier rising edge; a protected sector ignores it.
    // Erase commands are single cycles here; the erase clock pauses while suspended.
    always @(negedge wr_act) begin
        if (bus_in == 8'h90) sig_mode = 1'b1;
        else if (bus_in == 8'hF0) sig_mode = 1'b0;
        else if (bus_in == 8'h30 && susp) begin
            susp = 1'b0;
            t_go = $time;
        end else if (bus_in == 8'h30 && !busy && !prot[wr_addr[18:16]]) begin
            busy = 1'b1;
            e_sect = wr_addr[18:16];
            e_left = ERASE_NS;
            t_go = $time;
        end else if (bus_in == 8'hB0 && busy && !susp) begin
            susp = 1'b1;
            e_left = e_left - ($time - t_go);
        end else if (bus_in != 8'h30 && !prot[wr_addr[18:16]]) begin
            mem[wr_addr] = bus_in;
        end
    end
    // Timed strobe pulses under high voltage; a short pulse changes nothing.
    always @(negedge p.we_n) t_fall = $time;
    always @(posedge p.we_n) begin
        if (p.id_hv && p.oe_hv && !p.cs_hv && $time - t_fall >= PROT_NS)
            prot[p.addr[18:16]] = 1'b1;
        // Clears all sectors, and only once every sector was protected.
        if (p.id_hv && p.oe_hv && p.cs_hv && p.addr[6] && p.addr[12] && p.addr[16]
            && prot == 8'hFF && $time - t_fall >= UNPROT_NS)
            prot = 8'h00;
    end
    // Drives only with select and gate low, strobe high.
    assign drive_out = !p.cs_n && !p.oe_n && p.we_n && !p.oe_hv && !p.cs_hv;
    // Each new read of a busy, unsuspended device flips the toggle bit; completion is checked first.
    always @(posedge drive_out) begin
        if (busy && !susp && $time - t_go >= e_left) begin
            foreach (mem[a]) if (a[18:16] == e_sect) mem[a] = 8'hFF;
            busy = 1'b0;
        end
        if (busy && !susp) tog = ~tog;
    end
    // Read source follows pin levels and the last instruction.
    always @(p or prot or sig_mode or busy or susp or tog) begin
        if (p.id_hv && (p.addr[1] || p.addr[6])) rd_val = {7'h00, prot[p.addr[18:16]]};
        else if (!p.id_hv && busy && !susp) rd_val = {1'b0, tog, 6'h00};
        else if (p.id_hv || sig_mode) rd_val = p.addr[0] ? PART : MAKER;
        else rd_val = mem.exists(p.addr) ? mem[p.addr] : 8'hFF;
    end
    // A floating bus shows the inverse, so a stale byte can never pass.
    assign dq_out = drive_out ? rd_val : ~rd_val;
endmodule
`default_nettype wire

// ===== verif/flash_bus_ops_sector_protect_tb.sv
// Self-checking bench for the flash host controller against the device model.
`default_nettype none
module flash_bus_ops_sector_protect_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         P_CYC = 20;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
    localparam logic [7:0] PART  = 8'hC3; // Arbitrary value.
    logic               ref_clk;
    logic               rstn;
    logic               req_valid;
    fbp_pkg::fbp_req_t  req;
    logic               req_ready;
    logic               rsp_valid;
    logic [7:0]         rsp_data;
    fbp_pkg::fbp_pins_t pins;
    logic [7:0]         flash_dq;
    logic               flash_drive;
    logic [7:0]         bus;
    logic [7:0]         q;
    int                 n_mismatch;
    int                 n_compared;

    // The host owns the bus only while it enables its drivers.
    assign bus = pins.dq_oe ? pins.dq_o : flash_dq;

    fbp_host #(.PROTECT_CYC(P_CYC), .UNPROTECT_CYC(P_CYC)) dut_u (
        .ref_clk_in   (ref_clk),
        .rstn_in      (rstn),
        .req_valid_in (req_valid),
        .req_in       (req),
        .req_ready_out(req_ready),
        .rsp_valid_out(rsp_valid),
        .rsp_data_out (rsp_data),
        .pins_out     (pins),
        .dq_in        (bus)
    );
    fbp_flash_model #(.PROT_NS(P_CYC * 100), .UNPROT_NS(P_CYC * 100), .MAKER(MAKER),
                      .PART(PART)) flash_u (
        .pins_in  (pins),
        .bus_in   (bus),
        .dq_out   (flash_dq),
        .drive_out(flash_drive)
    );

    // Free-running 10 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            n_mismatch++;
        end
    endtask

    // Waits a bounded time for a flag; running out ends the run.
    task automatic wait_hi(input string what, input int lim, ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim) begin
                check(what, 8'h01, 8'h00);
                end_of_test();
            end
        end
    endtask

    // One request held until taken, then its answer or the return to idle.
    task automatic op(input fbp_pkg::fbp_op_t k, input logic [18:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        req_valid = 1'b1;
        req = '{op: k, addr: a, data: d};
        wait_hi("req_ready_out", 500, req_ready);
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        r = 8'h00;
        if (k inside {fbp_pkg::FBP_OP_READ, fbp_pkg::FBP_OP_ID_READ,
                      fbp_pkg::FBP_OP_PROT_CHECK}) begin
            wait_hi("rsp_valid_out", 50, rsp_valid);
            r = rsp_data;
        end
        else wait_hi("req_ready_out", 500, req_ready);
    endtask

    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        op(fbp_pkg::FBP_OP_WRITE, a, d, q);
    endtask

    task automatic rd(input fbp_pkg::fbp_op_t k, input logic [18:0] a, input logic [7:0] e,
                      input string what);
        logic [7:0] r;
        op(k, a, 8'h00, r);
        check(what, e, r);
    endtask

    // Back-to-back writes, then the same byte read twice.
    task automatic t_write_read();
        wr(19'h2_0010, 8'hA5);
        wr(19'h2_0011, 8'h3C);
        rd(fbp_pkg::FBP_OP_READ, 19'h2_0010, 8'hA5, "array byte");
        rd(fbp_pkg::FBP_OP_READ, 19'h2_0011, 8'h3C, "array byte");
        rd(fbp_pkg::FBP_OP_READ, 19'h2_0010, 8'hA5, "array reread");
        $display("test write_read finished");
    endtask

    // Codes picked by the lowest bit, upper bits ignored; then the instruction path.
    task automatic t_id();
        rd(fbp_pkg::FBP_OP_ID_READ, 19'h0_0000, MAKER, "maker code");
        rd(fbp_pkg::FBP_OP_ID_READ, 19'h5_A001, PART, "part code");
        wr(19'h0_0000, 8'h90);
        rd(fbp_pkg::FBP_OP_READ, 19'h0_0001, PART, "signature part");
        rd(fbp_pkg::FBP_OP_READ, 19'h0_0000, MAKER, "signature maker");
        wr(19'h0_0000, 8'hF0);
        rd(fbp_pkg::FBP_OP_READ, 19'h2_0010, 8'hA5, "array after reset");
        $display("test id finished");
    endtask

    // One sector protected: its status reads set and writes to it are lost.
    task automatic t_protect();
        wr(19'h3_0000, 8'h11);
        op(fbp_pkg::FBP_OP_PROTECT, 19'h3_0000, 8'h00, q);
        rd(fbp_pkg::FBP_OP_PROT_CHECK, 19'h3_0000, 8'h01, "sector 3 status");
        rd(fbp_pkg::FBP_OP_PROT_CHECK, 19'h4_0000, 8'h00, "sector 4 status");
        op(fbp_pkg::FBP_OP_UNPROTECT, 19'h1_1040, 8'h00, q);
        rd(fbp_pkg::FBP_OP_PROT_CHECK, 19'h3_0000, 8'h01, "refused unprotect");
        wr(19'h3_0000, 8'h22);
        rd(fbp_pkg::FBP_OP_READ, 19'h3_0000, 8'h11, "protected byte");
        wr(19'h4_0000, 8'h22);
        rd(fbp_pkg::FBP_OP_READ, 19'h4_0000, 8'h22, "open byte");
        $display("test protect finished");
    endtask

    // All sectors protected, one unprotect clears every one of them.
    task automatic t_unprotect();
        for (int s = 0; s < 8; s++)
            op(fbp_pkg::FBP_OP_PROTECT, {s[2:0], 16'h0}, 8'h00, q);
        for (int s = 0; s < 8; s++)
            rd(fbp_pkg::FBP_OP_PROT_CHECK, {s[2:0], 16'h0}, 8'h01, "sector set");
        op(fbp_pkg::FBP_OP_UNPROTECT, 19'h1_1040, 8'h00, q);
        for (int s = 0; s < 8; s++)
            rd(fbp_pkg::FBP_OP_PROT_CHECK, {s[2:0], 16'h0}, 8'h00, "sector clear");
        wr(19'h3_0000, 8'h44);
        rd(fbp_pkg::FBP_OP_READ, 19'h3_0000, 8'h44, "unprotected byte");
        $display("test unprotect finished");
    endtask

    // Erase runs alone, pauses for a read elsewhere, and leaves the sector blank.
    task automatic t_erase();
        logic [7:0] r1;
        logic [7:0] r2;
        wr(19'h5_0020, 8'h66);
        wr(19'h5_0000, 8'h30);
        op(fbp_pkg::FBP_OP_READ, 19'h5_0000, 8'h00, r1);
        op(fbp_pkg::FBP_OP_READ, 19'h5_0000, 8'h00, r2);
        check("busy toggle", {7'h00, ~r1[6]}, {7'h00, r2[6]});
        wr(19'h0_0000, 8'hB0);
        rd(fbp_pkg::FBP_OP_READ, 19'h2_0010, 8'hA5, "read in suspend");
        wr(19'h0_0000, 8'h30);
        repeat (120) @(posedge ref_clk);
        #1;
        op(fbp_pkg::FBP_OP_READ, 19'h5_0020, 8'h00, r1);
        op(fbp_pkg::FBP_OP_READ, 19'h5_0020, 8'h00, r2);
        check("steady toggle", r1, r2);
        check("erased byte", 8'hFF, r1);
        $display("test erase finished");
    endtask

    // Host and device never drive together, and a write strobe keeps the gate high.
    always @(posedge ref_clk) begin
        if (rstn && pins.dq_oe === 1'b1)
            check("device drive", 8'h00, {7'h00, flash_drive});
        if (rstn && pins.we_n === 1'b0 && pins.oe_hv !== 1'b1)
            check("gate in write", 8'h01, {7'h00, pins.oe_n});
    end

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (8) @(posedge ref_clk);
        #1;
        check("idle strobes", 8'h07, {5'h00, pins.cs_n, pins.oe_n, pins.we_n});
        rstn = 1'b1;
        t_write_read();
        t_id();
        t_protect();
        t_unprotect();
        t_erase();
        end_of_test();
    end
endmodule
`default_nettype wire
